// >>> bench/pimf_cpu_model.sv
// CPU side model: single-nibble reads and writes into the flag bank.
// Assumes the bank takes rd or wr on a rising edge and answers a read one cycle later.
`timescale 1ns/1ps

module pimf_cpu_model (
   input  wire logic                  clock, // Bus clock
   output pimf_pkg::pimf_bus_req_type bus,   // Access towards the bank
   input  wire logic [3:0]            rdata, // Read nibble
   input  wire logic                  rvalid // Read hit a mapped place
);
   // Idle bus with no strobe at time zero
   initial bus = '{rd: 1'b0, wr: 1'b0, addr: 16'h0000, wdata: 4'h0};

   // Released bus: address and data flip so stale values never look valid
   task automatic release_bus();
      bus <= '{rd: 1'b0, wr: 1'b0, addr: ~bus.addr, wdata: ~bus.wdata};
   endtask

   // One-cycle write strobe, launched just after an edge
   task automatic wr(input logic [15:0] a, input logic [3:0] w);
      @(posedge clock);
      bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: w};
      @(posedge clock);
      release_bus();
   endtask

   // One-cycle read strobe; the answer is settled just after the taking edge
   task automatic rd(input logic [15:0] a, output logic [3:0] d, output logic v);
      @(posedge clock);
      bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 4'h0};
      @(posedge clock);
      release_bus();
      #1;
      d = rdata;
      v = rvalid;
   endtask
endmodule

// >>> bench/tb_pimf_bank.sv
// Self-checking bench for the mask and flag bank, with a CPU model on the bus.
// Assumes registered answers: flags one cycle after events, irq_req one after that.
`timescale 1ns/1ps

module tb_pimf_bank;
   logic                       clock;            // 125 MHz
   logic                       rst_b;            // Sync reset, low
   pimf_pkg::pimf_bus_req_type bus;              // Driven by the CPU model
   logic [3:0]                 rdata;            // Read nibble
   logic                       rvalid;           // Read mapped
   logic [8:0][3:0]            peripheral_event; // Set pulses
   logic [4:0][3:0]            outside_mask;     // Masks kept elsewhere
   logic [3:0][3:0]            mask_out;         // Local masks
   logic                       irq_req;          // Request to CPU
   int                         miscompares;      // Mismatches seen
   int                         n_checks;         // Comparisons made
   logic [3:0]                 flg [9];          // Reference flags
   logic [3:0]                 msk [4];          // Reference local masks
   logic [3:0]                 d;                // Last read nibble
   logic                       v;                // Last read valid

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   pimf_bank u_dut (.clock(clock), .rst_b(rst_b), .bus(bus), .rdata(rdata), .rvalid(rvalid),
      .peripheral_event(peripheral_event), .outside_mask(outside_mask),
      .mask_out(mask_out), .irq_req(irq_req));
   pimf_cpu_model u_cpu (.clock(clock), .bus(bus), .rdata(rdata), .rvalid(rvalid));

   // Single comparison point
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Verdict and end of run
   task automatic wrap_up();
      $display("checks=%0d miscompares=%0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Reference request: flags 0..4 use outside masks, 5..8 the local ones
   function automatic logic irq_model();
      logic       r;
      logic [3:0] m;
      r = 1'b0;
      for (int i = 0; i < 9; i++) begin
         m = (i < 5) ? outside_mask[i] : msk[i-5];
         if ((flg[i] & m) != 4'h0) r = 1'b1;
      end
      return r;
   endfunction

   // Pulse events for one cycle and note what should latch
   task automatic fire(input logic [8:0][3:0] e);
      @(posedge clock);
      peripheral_event <= e;
      @(posedge clock);
      peripheral_event <= '0;
      for (int i = 0; i < 9; i++) flg[i] |= e[i] & pimf_pkg::PIMF_FLAG_VALID[i];
   endtask

   task automatic wr_flag(input int i, input logic [3:0] w);
      u_cpu.wr(pimf_pkg::PIMF_OFS_PT_FLAG + 16'(i), w);
      flg[i] &= ~w;
   endtask

   task automatic wr_mask(input int i, input logic [3:0] w);
      u_cpu.wr(pimf_pkg::PIMF_OFS_SW_MASK + 16'(i), w);
      msk[i] = w & pimf_pkg::PIMF_MASK_VALID[i];
   endtask

   // Read every register plus one unmapped place and compare with the model
   task automatic read_all();
      for (int i = 0; i < 9; i++) begin
         u_cpu.rd(pimf_pkg::PIMF_OFS_PT_FLAG + 16'(i), d, v);
         check({11'h0, v, d}, {11'h1, flg[i]});
      end
      for (int i = 0; i < 4; i++) begin
         u_cpu.rd(pimf_pkg::PIMF_OFS_SW_MASK + 16'(i), d, v);
         check({11'h0, v, d}, {11'h1, msk[i]});
      end
      u_cpu.rd(16'hffeb, d, v);
      check({11'h0, v, d}, 16'h0000);
   endtask

   // Let a change reach irq_req and mask_out, then compare both
   task automatic settle_check();
      repeat (2) @(posedge clock);
      #1;
      check({15'h0, irq_req}, {15'h0, irq_model()});
      check(mask_out, {msk[3], msk[2], msk[1], msk[0]});
   endtask

   task automatic model_reset();
      foreach (flg[i]) flg[i] = 4'h0;
      foreach (msk[i]) msk[i] = 4'h0;
   endtask

   // Hang guard: every wait is bounded, this cuts the whole run short
   initial begin
      repeat (100000) @(posedge clock);
      miscompares++;
      wrap_up();
   end

   initial begin
      rst_b = 1'b0;
      peripheral_event = '0;
      outside_mask = '0;
      model_reset();
      void'($urandom(66));
      repeat (20) @(posedge clock);
      rst_b <= 1'b1;
      // Everything starts cleared
      read_all();
      settle_check();
      $display("test reset values done");
      // All-ones into every mask: only implemented bits stick
      for (int i = 0; i < 4; i++) wr_mask(i, 4'hf);
      settle_check();
      read_all();
      $display("test masks done");
      // Every event bit at once, then random partial clears
      fire('1);
      read_all();
      for (int i = 0; i < 9; i++) wr_flag(i, 4'($urandom));
      // Clock timer event and a clear of all its bits in one cycle: set wins
      fork
         fire({16'h0000, 4'h5, 16'h0000});
         u_cpu.wr(pimf_pkg::PIMF_OFS_CT_FLAG, 4'hf);
      join
      flg[4] = 4'h5;
      read_all();
      settle_check();
      $display("test flags done");
      // Pending but masked dialer event: clear it before enabling
      wr_mask(2, 4'h0);
      fire(36'h0_1000_0000);
      wr_flag(7, 4'h1);
      wr_mask(2, 4'h1);
      settle_check();
      $display("test clear before enable done");
      // Random mix of events, mask writes, clears and outside masks
      for (int n = 0; n < 60; n++) begin
         @(posedge clock);
         outside_mask <= 20'($urandom);
         case ($urandom_range(2))
            0: fire({4'($urandom), 32'($urandom & $urandom)});
            1: wr_mask($urandom_range(3), 4'($urandom));
            default: wr_flag($urandom_range(8), 4'($urandom));
         endcase
         settle_check();
      end
      read_all();
      $display("test random traffic done");
      // Second reset in mid-run with flags and masks set
      fire('1);
      @(posedge clock);
      rst_b <= 1'b0;
      @(posedge clock);
      rst_b <= 1'b1;
      model_reset();
      settle_check();
      read_all();
      $display("test mid-run reset done");
      wrap_up();
   end
endmodule

// >>> design/pimf_bank.sv
// Interrupt mask and factor flag bank for the peripheral sources.
// Assumes peripherals and the CPU bus share this clock, events are
// one-cycle pulses, and outside masks come from flops on this clock.
//
// Contract
// - Stopwatch mask at ffe7, bits 1..0, reset 0
// - Serial 2 masks at ffe8, bits 2..0, reset 0
// - Dialer mask at ffe9 bit 0, reset 0
// - FSK masks at ffea, bits 1..0, reset 0
// - Timer flags fff2, write one clears
// - Serial 1 flags fff3, write one clears
// - Key group flags fff4, fff5 bit 0
// - Clock timer flags fff6, four bits, W1C
// - Stopwatch flags fff7, write one clears
// - Serial 2 flags fff8, write one clears
// - Dialer flag fff9 bit 0, W1C
// - FSK flags fffa, write one clears
// - Unused bits always read zero
// - All masks and flags zero after reset
`timescale 1ns/1ps

module pimf_bank #(
   parameter int NFLAG = pimf_pkg::PIMF_NFLAG, // Flag registers
   parameter int NMASK = pimf_pkg::PIMF_NMASK, // Local mask registers
   parameter int NOUT  = pimf_pkg::PIMF_NOUT   // Externally masked flags
) (
   input  wire logic                         clock,      // 125 MHz clock
   input  wire logic                         rst_b,      // Sync reset, low
   input  wire pimf_pkg::pimf_bus_req_type   bus,        // CPU access
   output logic [3:0]                        rdata,      // Read nibble
   output logic                              rvalid,     // Read was mapped
   input  wire logic [NFLAG-1:0][3:0]        peripheral_event, // Set pulses
   input  wire logic [NOUT-1:0][3:0]         outside_mask,     // Masks kept elsewhere
   output logic [NMASK-1:0][3:0]             mask_out,   // Local mask bits
   output logic                              irq_req     // Request to CPU
);

   // Storage
   logic [NFLAG-1:0][3:0] flag;       // Factor flags
   logic [NMASK-1:0][3:0] mask;       // Local mask bits
   logic [NFLAG-1:0][3:0] eff_mask;   // Mask seen by each flag register
   logic [NFLAG-1:0][3:0] clr_vec;    // Write-one-clear bits this cycle
   logic [NFLAG-1:0][3:0] set_vec;    // Implemented event bits this cycle
   logic [NFLAG-1:0][3:0] keep_vec;   // Flag bits not being cleared
   logic [NFLAG-1:0][3:0] next_flag;  // Next flag values
   logic [4:0]            fsel;       // Flag decode, bit 4 is the hit
   logic [4:0]            msel;       // Mask decode, bit 4 is the hit
   logic [3:0]            next_rdata; // Read mux result
   logic                  next_rvalid;// Read address was mapped
   logic [3:0]            rd_map;     // Implemented bits of last read

   // Decode a flag register address into a hit and an index
   function automatic logic [4:0] flag_sel(input logic [15:0] a);
      logic [4:0] s;
      s = 5'h00;
      if (a == pimf_pkg::PIMF_OFS_PT_FLAG) begin
         s = 5'h10;
      end else if (a == pimf_pkg::PIMF_OFS_S1_FLAG) begin
         s = 5'h11;
      end else if (a == pimf_pkg::PIMF_OFS_K0_FLAG) begin
         s = 5'h12;
      end else if (a == pimf_pkg::PIMF_OFS_K1_FLAG) begin
         s = 5'h13;
      end else if (a == pimf_pkg::PIMF_OFS_CT_FLAG) begin
         s = 5'h14;
      end else if (a == pimf_pkg::PIMF_OFS_SW_FLAG) begin
         s = 5'h15;
      end else if (a == pimf_pkg::PIMF_OFS_S2_FLAG) begin
         s = 5'h16;
      end else if (a == pimf_pkg::PIMF_OFS_DL_FLAG) begin
         s = 5'h17;
      end else if (a == pimf_pkg::PIMF_OFS_FSK_FLAG) begin
         s = 5'h18;
      end
      return s;
   endfunction

   // Decode a mask register address into a hit and an index
   function automatic logic [4:0] mask_sel(input logic [15:0] a);
      logic [4:0] s;
      s = 5'h00;
      if (a == pimf_pkg::PIMF_OFS_SW_MASK) begin
         s = 5'h10;
      end else if (a == pimf_pkg::PIMF_OFS_S2_MASK) begin
         s = 5'h11;
      end else if (a == pimf_pkg::PIMF_OFS_DL_MASK) begin
         s = 5'h12;
      end else if (a == pimf_pkg::PIMF_OFS_FSK_MASK) begin
         s = 5'h13;
      end
      return s;
   endfunction

   // Address decode, shared by read and write paths
   always_comb begin
      fsel = flag_sel(bus.addr);
      msel = mask_sel(bus.addr);
   end

   // Flag update: events set, a written one clears, set wins
   always_comb begin
      for (int i = 0; i < NFLAG; i++) begin
         // Only the addressed register sees the write
         if (bus.wr && fsel[4] && (fsel[3:0] == 4'(i))) begin
            clr_vec[i] = bus.wdata;
         end else begin
            clr_vec[i] = 4'h0;
         end
         // Unused positions never capture an event
         set_vec[i]   = peripheral_event[i] & pimf_pkg::PIMF_FLAG_VALID[i];
         keep_vec[i]  = flag[i] & ~clr_vec[i];
         // A pulse in the clearing cycle survives the clear
         next_flag[i] = keep_vec[i] | set_vec[i];
      end
   end

   // Flag registers
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         for (int i = 0; i < NFLAG; i++) begin
            flag[i] <= pimf_pkg::PIMF_RST_VAL;
         end
      end else begin
         flag <= next_flag;
      end
   end

   // Local mask registers, plain read-write with unused bits dropped
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         for (int j = 0; j < NMASK; j++) begin
            mask[j] <= pimf_pkg::PIMF_RST_VAL;
         end
      end else if (bus.wr && msel[4]) begin
         // Writing one enables, zero masks
         mask[msel[1:0]] <= bus.wdata & pimf_pkg::PIMF_MASK_VALID[msel[1:0]];
      end
   end

   // Mask seen by each flag: low ones from outside, high ones local
   always_comb begin
      for (int i = 0; i < NFLAG; i++) begin
         if (i < NOUT) begin
            eff_mask[i] = outside_mask[i];
         end else begin
            eff_mask[i] = mask[i - NOUT];
         end
      end
   end

   // Request is registered, so it trails the flag by one cycle
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         irq_req <= 1'b0;
      end else begin
         irq_req <= |(flag & eff_mask);
      end
   end

   // Copy of the local masks for the core's interrupt logic
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         mask_out <= '0;
      end else begin
         mask_out <= mask;
      end
   end

   // Read mux; unmapped addresses return zero with no valid
   always_comb begin
      next_rdata  = 4'h0;
      next_rvalid = 1'b0;
      if (fsel[4]) begin
         next_rdata  = flag[fsel[3:0]] & pimf_pkg::PIMF_FLAG_VALID[fsel[3:0]];
         next_rvalid = 1'b1;
      end else if (msel[4]) begin
         next_rdata  = mask[msel[1:0]] & pimf_pkg::PIMF_MASK_VALID[msel[1:0]];
         next_rvalid = 1'b1;
      end
   end

   // Read data is held until the next read, one cycle after the strobe
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         rdata  <= 4'h0;
         rvalid <= 1'b0;
      end else if (bus.rd) begin
         rdata  <= next_rdata;
         rvalid <= next_rvalid;
      end else begin
         rvalid <= 1'b0;
      end
   end

   // Helper for checks: implemented bits of the last read
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         rd_map <= 4'h0;
      end else if (bus.rd) begin
         if (fsel[4]) begin
            rd_map <= pimf_pkg::PIMF_FLAG_VALID[fsel[3:0]];
         end else if (msel[4]) begin
            rd_map <= pimf_pkg::PIMF_MASK_VALID[msel[1:0]];
         end else begin
            rd_map <= 4'h0;
         end
      end
   end

   // Checks on the mask registers. Each antecedent also asks for a sampled
   // high reset: disable iff reads the reset level of the current time step,
   // so at the edge where the flops take a synchronous reset it may already
   // see the released level and would otherwise compare against stale state.
   sw_mask_wr_a : assert property (@(posedge clock) disable iff (!rst_b)
      (rst_b && bus.wr && bus.addr == pimf_pkg::PIMF_OFS_SW_MASK)
      |=> mask[0] == ($past(bus.wdata) & pimf_pkg::PIMF_MASK_VALID[0]))
      else $error("Stopwatch mask write not stored");

   s2_mask_wr_a : assert property (@(posedge clock) disable iff (!rst_b)
      (rst_b && bus.wr && bus.addr == pimf_pkg::PIMF_OFS_S2_MASK)
      |=> mask[1] == ($past(bus.wdata) & pimf_pkg::PIMF_MASK_VALID[1]))
      else $error("Serial 2 mask write not stored");

   dl_mask_wr_a : assert property (@(posedge clock) disable iff (!rst_b)
      (rst_b && bus.wr && bus.addr == pimf_pkg::PIMF_OFS_DL_MASK)
      |=> mask[2] == ($past(bus.wdata) & pimf_pkg::PIMF_MASK_VALID[2]))
      else $error("Dialer mask write not stored");

   fsk_mask_wr_a : assert property (@(posedge clock) disable iff (!rst_b)
      (rst_b && bus.wr && bus.addr == pimf_pkg::PIMF_OFS_FSK_MASK)
      |=> mask[3] == ($past(bus.wdata) & pimf_pkg::PIMF_MASK_VALID[3]))
      else $error("FSK mask write not stored");

   // No write, no change: reads and released bus values leave the masks alone
   mask_hold_a : assert property (@(posedge clock) disable iff (!rst_b)
      (rst_b && !(bus.wr && msel[4])) |=> $stable(mask))
      else $error("Mask changed without a write");

   // Reserved mask positions are never stored
   for (genvar k = 0; k < NMASK; k++) begin : g_mask_chk
      mask_unused_a : assert property (@(posedge clock) disable iff (!rst_b)
         (mask[k] & ~pimf_pkg::PIMF_MASK_VALID[k]) == 4'h0)
         else $error("Unused mask bit set");
   end

   // The copy for the core trails the local masks by one cycle
   mask_out_a : assert property (@(posedge clock) disable iff (!rst_b)
      rst_b |=> (mask_out == $past(mask)))
      else $error("Mask copy out of step");

   // Checks on each flag register
   for (genvar g = 0; g < NFLAG; g++) begin : g_flag_chk
      flag_clear_a : assert property (@(posedge clock) disable iff (!rst_b)
         (rst_b && clr_vec[g] != 4'h0)
         |=> ((flag[g] & $past(clr_vec[g]) & ~$past(set_vec[g])) == 4'h0))
         else $error("Flag not cleared by write of one");

      flag_keep_a : assert property (@(posedge clock) disable iff (!rst_b)
         rst_b |=> ((flag[g] & $past(keep_vec[g])) == $past(keep_vec[g])))
         else $error("Flag lost without a write of one");

      set_wins_a : assert property (@(posedge clock) disable iff (!rst_b)
         (rst_b && set_vec[g] != 4'h0)
         |=> ((flag[g] & $past(set_vec[g])) == $past(set_vec[g])))
         else $error("Event lost");

      unused_zero_a : assert property (@(posedge clock) disable iff (!rst_b)
         (flag[g] & ~pimf_pkg::PIMF_FLAG_VALID[g]) == 4'h0)
         else $error("Unused flag bit set");
   end

   // Clears seen straight from the bus, so a broken clear vector or a
   // wrong decode shows here even though the loop above uses that vector
   ct_clear_a : assert property (@(posedge clock) disable iff (!rst_b)
      (rst_b && bus.wr && bus.addr == pimf_pkg::PIMF_OFS_CT_FLAG)
      |=> ((flag[4] & $past(bus.wdata & ~peripheral_event[4])) == 4'h0))
      else $error("Clock timer flag not cleared");

   dl_clear_a : assert property (@(posedge clock) disable iff (!rst_b)
      (rst_b && bus.wr && bus.addr == pimf_pkg::PIMF_OFS_DL_FLAG
       && bus.wdata[0] && !peripheral_event[7][0])
      |=> !flag[7][0])
      else $error("Dialer flag not cleared");

   // Key group flags both set when both groups pulse in the same cycle
   key_flag_a : assert property (@(posedge clock) disable iff (!rst_b)
      (rst_b && peripheral_event[2][0] && peripheral_event[3][0])
      |=> (flag[2][0] && flag[3][0]))
      else $error("Key group flag missed");

   fsk_flag_a : assert property (@(posedge clock) disable iff (!rst_b)
      (rst_b && peripheral_event[8][1] && !clr_vec[8][1]) ##1 (rst_b && clr_vec[8] == 4'h0)
      |=> flag[8][1])
      else $error("FSK ring flag not held");

   // Read path: no unused bit, mapped nibbles as stored, unmapped refused
   rd_unused_a : assert property (@(posedge clock) disable iff (!rst_b)
      $past(bus.rd) |-> ((rdata & ~rd_map) == 4'h0))
      else $error("Unused bit read as one");

   rd_flag_a : assert property (@(posedge clock) disable iff (!rst_b)
      (rst_b && bus.rd && fsel[4])
      |=> (rvalid && rdata == $past(flag[fsel[3:0]])))
      else $error("Flag read returned a wrong nibble");

   rd_mask_a : assert property (@(posedge clock) disable iff (!rst_b)
      (rst_b && bus.rd && msel[4])
      |=> (rvalid && rdata == $past(mask[msel[1:0]])))
      else $error("Mask read returned a wrong nibble");

   rd_unmapped_a : assert property (@(posedge clock) disable iff (!rst_b)
      (rst_b && bus.rd && !fsel[4] && !msel[4])
      |=> (!rvalid && rdata == 4'h0))
      else $error("Unmapped read answered");

   // The read nibble stands until the next read, valid for one cycle only
   rd_hold_a : assert property (@(posedge clock) disable iff (!rst_b)
      (rst_b && !bus.rd) |=> $stable(rdata))
      else $error("Read nibble changed without a read");

   rvalid_pulse_a : assert property (@(posedge clock) disable iff (!rst_b)
      (rst_b && !bus.rd) |=> !rvalid)
      else $error("Read valid without a read");

   // Reset clears everything on the following edge
   reset_clr_a : assert property (@(posedge clock)
      !rst_b |=> (flag == '0 && mask == '0 && mask_out == '0 && rdata == 4'h0
                  && !irq_req && !rvalid))
      else $error("State not cleared by reset");

   // Request follows enabled flags and drops once they clear; both the
   // local and the outside mask paths are watched
   irq_set_a : assert property (@(posedge clock) disable iff (!rst_b)
      (rst_b && (flag[5] & mask[0]) != 4'h0) |=> irq_req)
      else $error("Request missing for enabled flag");

   irq_outside_a : assert property (@(posedge clock) disable iff (!rst_b)
      (rst_b && (flag[0] & outside_mask[0]) != 4'h0) |=> irq_req)
      else $error("Request missing for outside mask");

   irq_drop_a : assert property (@(posedge clock) disable iff (!rst_b)
      ((flag & eff_mask) == '0) [*2] |-> !irq_req)
      else $error("Request without an enabled flag");

endmodule

// >>> design/pimf_pkg.sv
// Package for the peripheral interrupt mask and factor flag bank.
// Assumes a 4-bit CPU data bus with a 16-bit I/O address, all on one clock.
package pimf_pkg;

   // Bus and bank shape
   localparam int PIMF_AW    = 16; // I/O address width
   localparam int PIMF_DW    = 4;  // Data nibble width
   localparam int PIMF_NFLAG = 9;  // Flag registers in the bank
   localparam int PIMF_NMASK = 4;  // Mask registers held here
   localparam int PIMF_NOUT  = 5;  // Flag registers masked from outside

   // Mask register offsets
   localparam logic [15:0] PIMF_OFS_SW_MASK  = 16'hffe7; // Stopwatch mask
   localparam logic [15:0] PIMF_OFS_S2_MASK  = 16'hffe8; // Serial 2 mask
   localparam logic [15:0] PIMF_OFS_DL_MASK  = 16'hffe9; // Dialer mask
   localparam logic [15:0] PIMF_OFS_FSK_MASK = 16'hffea; // FSK mask

   // Flag register offsets
   localparam logic [15:0] PIMF_OFS_PT_FLAG  = 16'hfff2; // Programmable timers
   localparam logic [15:0] PIMF_OFS_S1_FLAG  = 16'hfff3; // Serial 1
   localparam logic [15:0] PIMF_OFS_K0_FLAG  = 16'hfff4; // Key group 0
   localparam logic [15:0] PIMF_OFS_K1_FLAG  = 16'hfff5; // Key group 1
   localparam logic [15:0] PIMF_OFS_CT_FLAG  = 16'hfff6; // Clock timer
   localparam logic [15:0] PIMF_OFS_SW_FLAG  = 16'hfff7; // Stopwatch
   localparam logic [15:0] PIMF_OFS_S2_FLAG  = 16'hfff8; // Serial 2
   localparam logic [15:0] PIMF_OFS_DL_FLAG  = 16'hfff9; // Dialer
   localparam logic [15:0] PIMF_OFS_FSK_FLAG = 16'hfffa; // FSK demodulator

   // Implemented bits per flag register, index 0 is the timer flags
   localparam logic [PIMF_NFLAG-1:0][3:0] PIMF_FLAG_VALID = {
      4'h3,  // 8: FSK ring bit 1, carrier bit 0
      4'h1,  // 7: Dialer bit 0
      4'h7,  // 6: Serial 2 error 2, tx 1, rx 0
      4'h3,  // 5: Stopwatch 1 Hz bit 1, 10 Hz bit 0
      4'hf,  // 4: Clock timer 1, 2, 8, 32 Hz on bits 3..0
      4'h1,  // 3: Key group 1 bit 0
      4'h1,  // 2: Key group 0 bit 0
      4'h7,  // 1: Serial 1 error 2, tx 1, rx 0
      4'h3   // 0: Timer 1 bit 1, timer 0 bit 0
   };

   // Implemented bits per mask register, same layout as its flags
   localparam logic [PIMF_NMASK-1:0][3:0] PIMF_MASK_VALID = {
      4'h3,  // 3: FSK
      4'h1,  // 2: Dialer
      4'h7,  // 1: Serial 2
      4'h3   // 0: Stopwatch
   };

   // Reset value of every mask and flag nibble
   localparam logic [3:0] PIMF_RST_VAL = 4'h0;

   // One CPU access to I/O memory
   typedef struct packed {
      logic        rd;    // Read strobe, one cycle
      logic        wr;    // Write strobe, one cycle
      logic [15:0] addr;  // I/O address
      logic [3:0]  wdata; // Write nibble
   } pimf_bus_req_type;

endpackage
